/* rtl/ldou_pkg.sv */
// Purpose: shared constants and types for the digit-to-segment opcode unit
// Assumes: 24-bit accumulators hold six packed BCD digits, digit 1 in the low nibble
// Notes: segment word per digit is {dp, g, f, e, d, c, b, a}
package ldou_pkg;

  // ***************************************************************
  // widths and counts
  // ***************************************************************
  localparam int unsigned LDOU_DIGITS = 6;
  localparam int unsigned LDOU_ACC_W = 24;
  localparam int unsigned LDOU_SEG_W = 8;
  localparam int unsigned LDOU_REG_W = 24;
  localparam logic [3:0] LDOU_DP_MIN = 4'h1;
  localparam logic [3:0] LDOU_DP_MAX = 4'h6;
  localparam logic [2:0] LDOU_DIGIT_LAST = 3'h5;
  localparam int unsigned LDOU_DP_BIT = 7;

  // ***************************************************************
  // segment registers of the display driver
  // ***************************************************************
  localparam logic [7:0] LDOU_SEG_REG_A = 8'h3D;
  localparam logic [7:0] LDOU_SEG_REG_B = 8'h3E;
  localparam logic [7:0] LDOU_SEG_REG_C = 8'h3F;
  localparam logic [LDOU_REG_W-1:0] LDOU_REG_RST = 24'h000000;

  // ***************************************************************
  // opcodes and timing
  // ***************************************************************
  localparam logic [7:0] LDOU_OP_NOP = 8'h00;
  localparam logic [7:0] LDOU_OP_DIG2SEG = 8'h01;
  localparam logic [7:0] LDOU_OP_DIG2SEG_ALT = 8'h02;
  localparam logic [7:0] LDOU_OP_REFRESH = 8'h03;
  localparam logic [1:0] LDOU_NOP_CYCLES = 2'h1;
  localparam logic [1:0] LDOU_REFRESH_CYCLES = 2'h3;

  localparam logic [6:0] LDOU_SEG_BLANK = 7'h00;

  typedef enum logic [2:0] {
    LDOU_ST_IDLE = 3'b000,
    LDOU_ST_CONV = 3'b001,
    LDOU_ST_WRITE = 3'b010,
    LDOU_ST_REFRESH = 3'b011,
    LDOU_ST_WAIT = 3'b100
  } ldou_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] dp_pos;
  } ldou_instr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [LDOU_REG_W-1:0] data;
  } ldou_seg_wr_t;

endpackage

/* rtl/ldou_seg_regs.sv */
// Purpose: the three display segment data registers with registered read port
// Assumes: one write port, one read port, same clock
// Notes: unknown addresses are ignored on write and read as zero
`timescale 1ns/1ps
module ldou_seg_regs (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // write port
  input wire logic wr_en_i,
  input wire ldou_pkg::ldou_seg_wr_t wr_i,
  // read port
  input wire logic [7:0] rd_addr_i,
  output logic [ldou_pkg::LDOU_REG_W-1:0] rd_data_o
);
  import ldou_pkg::*;

  logic [LDOU_REG_W-1:0] mem_q [3];
  logic [LDOU_REG_W-1:0] mem_d [3];
  logic [LDOU_REG_W-1:0] rd_d;

  function automatic logic [1:0] reg_index(input logic [7:0] addr);
    if (addr == LDOU_SEG_REG_A) begin
      return 2'h0;
    end else if (addr == LDOU_SEG_REG_B) begin
      return 2'h1;
    end else if (addr == LDOU_SEG_REG_C) begin
      return 2'h2;
    end else begin
      return 2'h3;
    end
  endfunction

  always_comb begin
    logic [1:0] wi;
    logic [1:0] ri;
    wi = reg_index(wr_i.addr);
    ri = reg_index(rd_addr_i);
    for (int i = 0; i < 3; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en_i && wi != 2'h3) begin
      mem_d[wi] = wr_i.data;
    end
    rd_d = (ri == 2'h3) ? LDOU_REG_RST : mem_q[ri];
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 3; i++) begin
        mem_q[i] <= LDOU_REG_RST;
      end
      rd_data_o <= LDOU_REG_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rd_data_o <= rd_d;
    end
  end

endmodule

/* rtl/ldou_top.sv */
// Purpose: executes the digit-to-segment, display refresh and no-operation opcodes
// Assumes: instructions arrive one at a time with a one-cycle start pulse
// Notes: digit results occupy registers A and B; register C is left to other opcodes
//
// Summary of operation
// - The conversion opcode turns all six decimal digits of the chosen accumulator into segment patterns.
// - The immediate 1 to 6 picks the digit position that carries the decimal point.
// - Zero digits left of the decimal point, up to the first non-zero digit, are shown blank.
// - The result goes straight into segment registers 61 and 62, not into an accumulator.
// - The refresh opcode sends segment registers 61 to 63 to the display driver.
// - The no-operation opcode takes one cycle and changes no register or flag.
`timescale 1ns/1ps
module ldou_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // instruction issue
  input wire logic start_i,
  input wire ldou_pkg::ldou_instr_t instr_i,
  output logic busy_o,
  output logic done_o,
  // accumulator sources
  input wire logic [ldou_pkg::LDOU_ACC_W-1:0] acc_x_i,
  input wire logic [ldou_pkg::LDOU_ACC_W-1:0] acc_y_i,
  // register 63 contents written by other opcodes
  input wire logic seg_c_wr_i,
  input wire logic [ldou_pkg::LDOU_REG_W-1:0] seg_c_data_i,
  // display driver transfer
  output logic lcd_load_o,
  output logic [ldou_pkg::LDOU_REG_W-1:0] lcd_data_o,
  output logic [1:0] lcd_word_o
);
  import ldou_pkg::*;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [6:0] seg_of(input logic [3:0] digit);
    case (digit)
      4'h0: seg_of = 7'h3F;
      4'h1: seg_of = 7'h06;
      4'h2: seg_of = 7'h5B;
      4'h3: seg_of = 7'h4F;
      4'h4: seg_of = 7'h66;
      4'h5: seg_of = 7'h6D;
      4'h6: seg_of = 7'h7D;
      4'h7: seg_of = 7'h07;
      4'h8: seg_of = 7'h7F;
      4'h9: seg_of = 7'h6F;
      default: seg_of = LDOU_SEG_BLANK;
    endcase
  endfunction

  // ***************************************************************
  // state
  // ***************************************************************
  ldou_state_t state_q, state_d;
  logic [LDOU_ACC_W-1:0] src_q, src_d;
  logic [3:0] dp_q, dp_d;
  logic [2:0] idx_q, idx_d;
  logic blank_q, blank_d;
  logic [LDOU_SEG_W*LDOU_DIGITS-1:0] segs_q, segs_d;
  logic [1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [1:0] word_q, word_d;
  logic rd_valid_q, rd_valid_d;
  logic [1:0] rd_word_q, rd_word_d;

  logic wr_en;
  ldou_seg_wr_t wr;
  logic [7:0] rd_addr;
  logic [LDOU_REG_W-1:0] rd_data;

  ldou_seg_regs u_regs (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_en),
    .wr_i(wr),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic [3:0] dig;
    logic [3:0] pos;
    logic [6:0] seg;
    dig = src_q[LDOU_ACC_W-1 -: 4];
    pos = 4'(LDOU_DIGITS) - {1'b0, idx_q};
    seg = seg_of(dig);
    state_d = state_q;
    src_d = src_q;
    dp_d = dp_q;
    idx_d = idx_q;
    blank_d = blank_q;
    segs_d = segs_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    rd_valid_d = 1'b0;
    rd_word_d = word_q;
    word_d = word_q;
    // side port owns the write port unless a conversion result is being stored
    wr_en = seg_c_wr_i;
    wr.addr = LDOU_SEG_REG_C;
    wr.data = seg_c_data_i;
    rd_addr = LDOU_SEG_REG_A;
    case (state_q)
      LDOU_ST_IDLE: begin
        if (start_i) begin
          if (instr_i.opcode == LDOU_OP_DIG2SEG || instr_i.opcode == LDOU_OP_DIG2SEG_ALT) begin
            src_d = (instr_i.opcode == LDOU_OP_DIG2SEG_ALT) ? acc_y_i : acc_x_i;
            dp_d = instr_i.dp_pos;
            if (instr_i.dp_pos < LDOU_DP_MIN || instr_i.dp_pos > LDOU_DP_MAX) begin
              dp_d = LDOU_DP_MIN;
            end
            idx_d = 3'h0;
            blank_d = 1'b1;
            state_d = LDOU_ST_CONV;
          end else if (instr_i.opcode == LDOU_OP_REFRESH) begin
            word_d = 2'h0;
            cnt_d = 2'h0;
            state_d = LDOU_ST_REFRESH;
          end else begin
            // unknown opcodes finish like a no-operation
            done_d = 1'b1;
          end
        end
      end
      LDOU_ST_CONV: begin
        // most significant digit first; digit 1 is the rightmost position
        if (dig != 4'h0 || pos <= dp_q) begin
          blank_d = 1'b0;
        end
        if (blank_q && dig == 4'h0 && pos > dp_q) begin
          seg = LDOU_SEG_BLANK;
        end
        segs_d = {segs_q[LDOU_SEG_W*(LDOU_DIGITS-1)-1:0], (pos == dp_q), seg};
        src_d = {src_q[LDOU_ACC_W-5:0], 4'h0};
        idx_d = idx_q + 3'h1;
        if (idx_q == LDOU_DIGIT_LAST) begin
          state_d = LDOU_ST_WRITE;
        end
      end
      LDOU_ST_WRITE: begin
        // a side port write to register 63 in this or the next cycle is lost
        wr_en = 1'b1;
        wr.addr = LDOU_SEG_REG_A;
        wr.data = segs_q[LDOU_REG_W-1:0];
        state_d = LDOU_ST_WAIT;
      end
      LDOU_ST_WAIT: begin
        wr_en = 1'b1;
        wr.addr = LDOU_SEG_REG_B;
        wr.data = segs_q[2*LDOU_REG_W-1:LDOU_REG_W];
        done_d = 1'b1;
        state_d = LDOU_ST_IDLE;
      end
      LDOU_ST_REFRESH: begin
        // read registers 61..63 in turn; each read lands one cycle later
        if (word_q == 2'h0) begin
          rd_addr = LDOU_SEG_REG_A;
        end else if (word_q == 2'h1) begin
          rd_addr = LDOU_SEG_REG_B;
        end else begin
          rd_addr = LDOU_SEG_REG_C;
        end
        rd_valid_d = 1'b1;
        rd_word_d = word_q;
        word_d = word_q + 2'h1;
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == LDOU_REFRESH_CYCLES - 2'h1) begin
          done_d = 1'b1;
          state_d = LDOU_ST_IDLE;
        end
      end
      default: begin
        state_d = LDOU_ST_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= LDOU_ST_IDLE;
      src_q <= '0;
      dp_q <= LDOU_DP_MIN;
      idx_q <= 3'h0;
      blank_q <= 1'b1;
      segs_q <= '0;
      cnt_q <= 2'h0;
      done_q <= 1'b0;
      word_q <= 2'h0;
      rd_valid_q <= 1'b0;
      rd_word_q <= 2'h0;
    end else begin
      state_q <= state_d;
      src_q <= src_d;
      dp_q <= dp_d;
      idx_q <= idx_d;
      blank_q <= blank_d;
      segs_q <= segs_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      word_q <= word_d;
      rd_valid_q <= rd_valid_d;
      rd_word_q <= rd_word_d;
    end
  end

  // display transfer: load pulses with the registered read word
  assign lcd_load_o = rd_valid_q;
  assign lcd_data_o = rd_data;
  assign lcd_word_o = rd_word_q;
  // busy is high in every state but idle, so a start during a conversion or refresh is dropped; a no-operation never raises it
  assign busy_o = (state_q != LDOU_ST_IDLE);
  assign done_o = done_q;

endmodule

/* tb/ldou_top_assertions.sv */
// Purpose: timing checks on the opcode unit ports
// Assumes: bound into ldou_top, one clock domain
// Notes: load and done bounds follow the hand-over timing
`timescale 1ns/1ps
module ldou_top_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire logic start_i,
  input wire ldou_pkg::ldou_instr_t instr_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic lcd_load_o,
  input wire logic [1:0] lcd_word_o
);
  import ldou_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ***************************************************************
  // taken requests
  // ***************************************************************
  sequence take_s(logic [7:0] op);
    start_i && !busy_o && instr_i.opcode == op;
  endsequence
  sequence conv_take_s;
    start_i && !busy_o && (instr_i.opcode == LDOU_OP_DIG2SEG || instr_i.opcode == LDOU_OP_DIG2SEG_ALT);
  endsequence
  sequence words_s;
    lcd_load_o && lcd_word_o == 2'h1 ##1 lcd_load_o && lcd_word_o == 2'h2;
  endsequence
  nop_one_cycle_a: assert property (take_s(LDOU_OP_NOP) |=> done_o)
    else $error("nop did not finish after one cycle");
  conv_busy_a: assert property (conv_take_s |=> busy_o [*6])
    else $error("conversion dropped busy early");
  conv_done_a: assert property (conv_take_s |-> ##9 done_o)
    else $error("conversion did not complete");
  conv_quiet_a: assert property (conv_take_s |-> ##3 !lcd_load_o [*5])
    else $error("conversion sent words to the display");
  refresh_load_a: assert property (take_s(LDOU_OP_REFRESH) |-> ##2 (lcd_load_o && lcd_word_o == 2'h0))
    else $error("refresh sent no first word");
  refresh_done_a: assert property (take_s(LDOU_OP_REFRESH) |-> ##4 done_o)
    else $error("refresh did not complete");
  word_order_a: assert property (lcd_load_o && lcd_word_o == 2'h0 |=> words_s)
    else $error("refresh words out of order");
  done_idle_a: assert property (done_o |-> !busy_o)
    else $error("done while busy");
  word_range_a: assert property (lcd_load_o |-> lcd_word_o != 2'h3)
    else $error("load of an unknown word");
endmodule

bind ldou_top ldou_top_chk u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
  .instr_i(instr_i), .busy_o(busy_o), .done_o(done_o), .lcd_load_o(lcd_load_o), .lcd_word_o(lcd_word_o));

/* tb/ldou_lcd_model.sv */
// Purpose: display driver model that latches the refresh words
// Assumes: one word per load pulse
// Notes: the glass only changes on a load
`timescale 1ns/1ps
module ldou_lcd_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // transfer from the opcode unit
  input wire logic lcd_load_i,
  input wire logic [1:0] lcd_word_i,
  input wire logic [23:0] lcd_data_i,
  // what the glass shows
  output logic [23:0] shown_o [3],
  output int loads_o
);
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shown_o <= '{24'h000000, 24'h000000, 24'h000000};
      loads_o <= 0;
    end else if (lcd_load_i && lcd_word_i != 2'h3) begin
      shown_o[lcd_word_i] <= lcd_data_i;
      loads_o <= loads_o + 1;
    end
  end
endmodule

/* tb/lcd_digit_opcode_unit_tb.sv */
// Purpose: self-checking bench for the opcode unit
// Assumes: display seen through the driver model
// Notes: each conversion is followed by a refresh
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module lcd_digit_opcode_unit_tb;
  import ldou_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic start_i = 1'b0;
  ldou_instr_t instr_i = '0;
  logic [23:0] acc_x_i = '0;
  logic [23:0] acc_y_i = '0;
  logic seg_c_wr_i = 1'b0;
  logic [23:0] seg_c_data_i = '0;
  logic busy_o, done_o, lcd_load_o;
  logic [23:0] lcd_data_o;
  logic [1:0] lcd_word_o;
  logic [23:0] shown [3];
  int loads;
  int n_fail = 0;
  int comparisons = 0;
  logic [6:0] seg7 [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  logic [7:0] ops [5] = '{LDOU_OP_DIG2SEG, LDOU_OP_DIG2SEG_ALT, LDOU_OP_DIG2SEG, LDOU_OP_DIG2SEG, LDOU_OP_DIG2SEG};
  logic [3:0] dps [5] = '{4'h3, 4'h6, 4'h1, 4'h4, 4'h9};
  logic [23:0] xs [5] = '{24'h000120, 24'h111111, 24'h000000, 24'h123456, 24'h0A0305};
  logic [23:0] ys [5] = '{24'h000000, 24'h987654, 24'h000000, 24'h000000, 24'h000000};
  always #5 ref_clk_i = ~ref_clk_i;
  ldou_top dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .instr_i(instr_i),
    .busy_o(busy_o), .done_o(done_o), .acc_x_i(acc_x_i), .acc_y_i(acc_y_i), .seg_c_wr_i(seg_c_wr_i),
    .seg_c_data_i(seg_c_data_i), .lcd_load_o(lcd_load_o), .lcd_data_o(lcd_data_o), .lcd_word_o(lcd_word_o));
  ldou_lcd_model u_lcd (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .lcd_load_i(lcd_load_o),
    .lcd_word_i(lcd_word_o), .lcd_data_i(lcd_data_o), .shown_o(shown), .loads_o(loads));
  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [47:0] exp_segs(logic [23:0] acc, logic [3:0] dp);
    int p;
    logic lead;
    logic [3:0] d;
    logic [7:0] s;
    p = (dp >= 4'h1 && dp <= 4'h6) ? int'(dp) : 1;
    lead = 1'b1;
    exp_segs = '0;
    for (int i = 6; i >= 1; i--) begin
      d = acc[4*i-4 +: 4];
      s = (d < 4'hA) ? {1'b0, seg7[d]} : 8'h00;
      if (i > p && lead && d == 4'h0) s = 8'h00;
      else lead = 1'b0;
      if (i == p) s[7] = 1'b1;
      exp_segs[8*i-8 +: 8] = s;
    end
  endfunction
  task automatic run_op(input logic [7:0] op, input logic [3:0] dp);
    int n;
    int n_exp;
    logic conv;
    n = 0;
    conv = (op == LDOU_OP_DIG2SEG || op == LDOU_OP_DIG2SEG_ALT);
    n_exp = conv ? int'(LDOU_DIGITS) + 2 : (op == LDOU_OP_REFRESH) ? int'(LDOU_REFRESH_CYCLES) : int'(LDOU_NOP_CYCLES) - 1;
    start_i = 1'b1;
    instr_i = '{opcode: op, dp_pos: dp};
    @(posedge ref_clk_i);
    #1 start_i = 1'b0;
    `CHK("busy", conv || op == LDOU_OP_REFRESH, busy_o)
    while (done_o !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    `CHK("done", 1'b1, done_o)
    `CHK("cycles", n_exp, n)
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_convert();
    int l0;
    logic [47:0] e;
    for (int k = 0; k < 5; k++) begin
      acc_x_i = xs[k];
      acc_y_i = ys[k];
      e = exp_segs(ops[k] == LDOU_OP_DIG2SEG_ALT ? ys[k] : xs[k], dps[k]);
      l0 = loads;
      run_op(ops[k], dps[k]);
      `CHK("quiet", l0, loads)
      run_op(LDOU_OP_REFRESH, 4'h0);
      `CHK("reg61", e[23:0], shown[0])
      `CHK("reg62", e[47:24], shown[1])
      `CHK("loads", l0 + 3, loads)
    end
  endtask
  task automatic t_reg63();
    seg_c_data_i = 24'h5A5A5A;
    seg_c_wr_i = 1'b1;
    @(posedge ref_clk_i);
    #1 seg_c_wr_i = 1'b0;
    run_op(LDOU_OP_REFRESH, 4'h0);
    `CHK("reg63", 24'h5A5A5A, shown[2])
  endtask
  task automatic t_nop();
    logic [23:0] s0;
    logic [23:0] s1;
    int l0;
    s0 = shown[0];
    s1 = shown[1];
    l0 = loads;
    acc_x_i = 24'h999999;
    run_op(LDOU_OP_NOP, 4'h2);
    run_op(LDOU_OP_NOP, 4'h2);
    run_op(8'h7F, 4'h2);
    `CHK("nop loads", l0, loads)
    run_op(LDOU_OP_REFRESH, 4'h0);
    `CHK("nop reg61", s0, shown[0])
    `CHK("nop reg62", s1, shown[1])
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1 rst_b_i = 1'b1;
    t_convert();
    t_reg63();
    t_nop();
    report_and_stop();
  end
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
endmodule
